// ### src/imd_core.sv
// Execute, DMA, interrupt and load cycles of an 8-bit processor core.
// Assumes opcodes arrive from fetch logic on the same clock; memory,
// I/O pins and request pins are outside the clock domain.
`include "imd_params.svh"
`timescale 1ns/1ps
// What this block does
// (RULE1) Load immediate byte into accumulator, advance counter
// (RULE2) OR/AND/XOR immediate into accumulator, advance counter
// (RULE3) Add immediate, carry out to carry bit
// (RULE4) Immediate minus accumulator, carry flags borrow
// (RULE5) Accumulator minus immediate, carry flags borrow
// (RULE6) DMA input writes bus byte at pointer
// (RULE7) DMA output reads memory at pointer
// (RULE8) DMA input wins over DMA output
// (RULE9) Interrupt saves selects, disables, sets selects
// (RULE10) Clear and wait low enter load idle
// (RULE11) Load mode suppresses first pulse, awaits DMA
// (RULE12) Shift left, top bit into carry
// (RULE13) I/O code lines stay zero
module imd_core (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Instruction from fetch logic
  input wire logic exec_req_in,
  input wire logic [7:0] exec_opcode_in,
  output logic exec_done_out,
  // Control pins, active low
  input wire logic clear_n_in,
  input wire logic wait_n_in,
  input wire logic dma_in_req_n_in,
  input wire logic dma_out_req_n_in,
  input wire logic int_req_n_in,
  // Data bus, read side only
  input wire logic [7:0] data_in,
  // Memory side
  output logic [15:0] mem_addr_out,
  output logic mem_read_strobe_n_out,
  output logic mem_write_strobe_n_out,
  output logic timing_pulse_a_out,
  output logic timing_pulse_b_out,
  output logic [2:0] io_code_lines_out,
  output imd_pkg::imd_state_t state_out
);
  // ****************************************
  // Declarations
  // ****************************************
  imd_pkg::imd_state_t state_q; // Current cycle kind
  logic [2:0] phase_q; // Clock within cycle
  imd_pkg::imd_op_t op_q; // Operation held
  logic exec_pend_q; // Instruction waiting
  logic dma_is_in_q; // DMA direction
  logic [7:0] acc_q; // Accumulator
  logic carry_q; // Carry bit
  logic [7:0] operand_q; // Captured bus byte
  logic [15:0] pc_q; // Program counter
  logic [15:0] dma_ptr_q; // DMA pointer
  logic [3:0] cs_q; // Counter select
  logic [3:0] ps_q; // Pointer select
  logic [7:0] saved_q; // Saved selects
  logic ie_q; // Interrupt enable
  logic [12:0] sync_w; // Synchronised pins
  logic clear_s, wait_s; // Clear, wait levels
  logic dma_in_s, dma_out_s; // DMA requests, high
  logic int_s; // Interrupt request, high
  logic [7:0] data_s; // Synchronised data
  logic load_mode; // Clear and wait low
  logic dma_any; // Any DMA request
  logic last_ph; // Final clock of cycle
  logic mem_op; // Exec reads memory
  logic strobe_ph; // Strobe window
  imd_alu_if alu_bus ();

  // ****************************************
  // Pin synchronisation and ALU
  // ****************************************
  imd_sync #(.W(13)) u_sync (
    .clk_in(core_clk_in),
    .rst_in(sys_rst_in),
    .async_in({clear_n_in, wait_n_in, dma_in_req_n_in, dma_out_req_n_in, int_req_n_in, data_in}),
    .sync_out(sync_w)
  );
  imd_alu u_alu (
    .a(alu_bus.alu)
  );

  // Decode of synchronised pins
  assign clear_s = sync_w[12];
  assign wait_s = sync_w[11];
  assign dma_in_s = ~sync_w[10];
  assign dma_out_s = ~sync_w[9];
  assign int_s = ~sync_w[8];
  assign data_s = sync_w[7:0];
  assign load_mode = ~clear_s & ~wait_s; // [RULE10]
  assign dma_any = dma_in_s | dma_out_s;
  assign last_ph = (phase_q == `IMD_PH_LAST);
  assign mem_op = (op_q != imd_pkg::IMD_OP_SHL);
  assign strobe_ph = (phase_q != `IMD_PH_TPA) && (phase_q != `IMD_PH_LAST);

  // ALU inputs
  assign alu_bus.op = op_q;
  assign alu_bus.acc = acc_q;
  assign alu_bus.operand = operand_q;

  // ****************************************
  // Cycle sequencer
  // ****************************************
  // Picks the next cycle at idle and steps the phase
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= imd_pkg::IMD_IDLE;
      phase_q <= 3'h0;
      dma_is_in_q <= 1'b0;
    end else begin
      unique case (state_q)
        imd_pkg::IMD_IDLE: begin
          phase_q <= 3'h0;
          // DMA first so load mode can be filled
          if (dma_any) begin
            state_q <= imd_pkg::IMD_DMA;
            dma_is_in_q <= dma_in_s; // [RULE8]
          end else if (load_mode) begin
            state_q <= imd_pkg::IMD_LOAD; // [RULE10]
          end else if (exec_pend_q) begin
            state_q <= imd_pkg::IMD_EXEC;
          end else if (int_s && ie_q) begin
            state_q <= imd_pkg::IMD_INT;
          end
        end
        imd_pkg::IMD_LOAD: begin
          phase_q <= 3'h0;
          // Idle here until a DMA request or release
          if (dma_any) begin
            state_q <= imd_pkg::IMD_DMA; // [RULE11]
            dma_is_in_q <= dma_in_s; // [RULE8]
          end else if (!load_mode) begin
            state_q <= imd_pkg::IMD_IDLE;
          end
        end
        default: begin
          // Exec, DMA and interrupt run a full cycle
          phase_q <= phase_q + 3'h1;
          if (last_ph) begin
            state_q <= imd_pkg::IMD_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Instruction intake
  // ****************************************
  // Holds one request; unsupported opcodes are dropped
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      exec_pend_q <= 1'b0;
      op_q <= imd_pkg::IMD_OP_LOAD;
    end else if (state_q == imd_pkg::IMD_EXEC && last_ph) begin
      exec_pend_q <= 1'b0;
    end else if (exec_req_in && !exec_pend_q && exec_opcode_in[7:4] == `IMD_IMM_HI
                 && exec_opcode_in[3]) begin
      exec_pend_q <= 1'b1;
      op_q <= imd_pkg::imd_op_t'(exec_opcode_in[3:0]);
    end
  end

  // Done pulse at the commit clock
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      exec_done_out <= 1'b0;
    end else begin
      exec_done_out <= (state_q == imd_pkg::IMD_EXEC) && last_ph;
    end
  end

  // ****************************************
  // Data path
  // ****************************************
  // Bus byte taken at the late timing pulse
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      operand_q <= 8'h00;
    end else if (phase_q == `IMD_PH_CAP) begin
      operand_q <= data_s;
    end
  end

  // Accumulator and carry commit
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      acc_q <= `IMD_RST_ACC;
      carry_q <= 1'b0;
    end else if (state_q == imd_pkg::IMD_EXEC && last_ph) begin
      acc_q <= alu_bus.result; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE12]
      if (alu_bus.carry_we) begin
        carry_q <= alu_bus.carry_out; // [RULE3] [RULE4] [RULE5] [RULE12]
      end
    end
  end

  // ****************************************
  // Pointers, selects and software writes
  // ****************************************
  // Hardware updates take priority over a same-cycle write
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pc_q <= `IMD_RST_PC;
    end else if (state_q == imd_pkg::IMD_EXEC && last_ph && mem_op) begin
      pc_q <= pc_q + 16'h0001; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
    end else if (reg_wr_in && reg_addr_in == `IMD_OFS_PC) begin
      pc_q <= reg_wdata_in[15:0];
    end
  end

  // DMA pointer steps after each DMA cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      dma_ptr_q <= `IMD_RST_DMAPTR;
    end else if (state_q == imd_pkg::IMD_DMA && last_ph) begin
      dma_ptr_q <= dma_ptr_q + 16'h0001; // [RULE6] [RULE7]
    end else if (reg_wr_in && reg_addr_in == `IMD_OFS_DMAPTR) begin
      dma_ptr_q <= reg_wdata_in[15:0];
    end
  end

  // Interrupt entry rewrites selects and enable
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cs_q <= 4'h0;
      ps_q <= 4'h0;
      saved_q <= 8'h00;
      ie_q <= 1'b1;
    end else if (state_q == imd_pkg::IMD_INT && last_ph) begin
      saved_q <= {ps_q, cs_q}; // [RULE9]
      ie_q <= 1'b0;
      cs_q <= `IMD_INT_CS;
      ps_q <= `IMD_INT_PS;
    end else if (reg_wr_in && reg_addr_in == `IMD_OFS_SEL) begin
      cs_q <= reg_wdata_in[`IMD_SEL_CS_LO +: 4];
      ps_q <= reg_wdata_in[`IMD_SEL_PS_LO +: 4];
      ie_q <= reg_wdata_in[`IMD_SEL_IE_BIT];
    end
  end

  // ****************************************
  // Memory side outputs
  // ****************************************
  // Address, strobes and pulses follow state one clock later
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mem_addr_out <= 16'h0000;
      mem_read_strobe_n_out <= 1'b1;
      mem_write_strobe_n_out <= 1'b1;
      timing_pulse_a_out <= 1'b0;
      timing_pulse_b_out <= 1'b0;
    end else begin
      mem_read_strobe_n_out <= 1'b1;
      mem_write_strobe_n_out <= 1'b1;
      timing_pulse_a_out <= 1'b0;
      timing_pulse_b_out <= 1'b0;
      unique case (state_q)
        imd_pkg::IMD_IDLE: begin
          // Hold last address
        end
        imd_pkg::IMD_EXEC: begin
          mem_addr_out <= pc_q;
          timing_pulse_a_out <= (phase_q == `IMD_PH_TPA);
          timing_pulse_b_out <= (phase_q == `IMD_PH_CAP);
          // Shift leaves the bus floating, strobes high
          mem_read_strobe_n_out <= ~(mem_op && strobe_ph); // [RULE1] [RULE12]
        end
        imd_pkg::IMD_DMA: begin
          mem_addr_out <= dma_ptr_q;
          timing_pulse_a_out <= (phase_q == `IMD_PH_TPA);
          timing_pulse_b_out <= (phase_q == `IMD_PH_CAP);
          mem_write_strobe_n_out <= ~(dma_is_in_q && strobe_ph); // [RULE6]
          mem_read_strobe_n_out <= ~(!dma_is_in_q && strobe_ph); // [RULE7]
        end
        imd_pkg::IMD_INT: begin
          // Bus floats, both strobes stay high
          mem_addr_out <= pc_q; // [RULE9]
          timing_pulse_a_out <= (phase_q == `IMD_PH_TPA);
          timing_pulse_b_out <= (phase_q == `IMD_PH_CAP);
        end
        imd_pkg::IMD_LOAD: begin
          // No timing pulse A while idling
          mem_addr_out <= dma_ptr_q - 16'h0001; // [RULE10] [RULE11]
          mem_read_strobe_n_out <= 1'b0;
        end
      endcase
    end
  end

  // I/O code lines and visible state
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      io_code_lines_out <= 3'h0;
      state_out <= imd_pkg::IMD_IDLE;
    end else begin
      io_code_lines_out <= 3'h0; // [RULE13]
      state_out <= state_q;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Data stand one clock after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `IMD_OFS_STATUS: reg_rdata_out <= {20'h0_0000, state_q, carry_q, acc_q};
        `IMD_OFS_PC: reg_rdata_out <= {16'h0000, pc_q};
        `IMD_OFS_DMAPTR: reg_rdata_out <= {16'h0000, dma_ptr_q};
        `IMD_OFS_SEL: reg_rdata_out <= {8'h00, saved_q, 7'h00, ie_q, ps_q, cs_q};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_commit(imd_pkg::imd_op_t o);
    state_q == imd_pkg::IMD_EXEC && last_ph && op_q == o;
  endsequence

  load_acc_a: assert property (s_commit(imd_pkg::IMD_OP_LOAD) |=> // [RULE1]
      acc_q == $past(operand_q) && pc_q == $past(pc_q) + 16'h0001)
    else $error("load immediate wrong");
  logic_ops_a: assert property (s_commit(imd_pkg::IMD_OP_OR) |=> // [RULE2]
      acc_q == ($past(acc_q) | $past(operand_q)))
    else $error("or immediate wrong");
  add_carry_a: assert property (s_commit(imd_pkg::IMD_OP_ADD) |=> // [RULE3]
      {carry_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(operand_q)})
    else $error("add immediate wrong");
  rsub_diff_a: assert property (s_commit(imd_pkg::IMD_OP_RSUB) |=> // [RULE4]
      acc_q == $past(operand_q) - $past(acc_q) && carry_q == ($past(operand_q) >= $past(acc_q)))
    else $error("reverse subtract wrong");
  sub_diff_a: assert property (s_commit(imd_pkg::IMD_OP_SUB) |=> // [RULE5]
      acc_q == $past(acc_q) - $past(operand_q) && carry_q == ($past(acc_q) >= $past(operand_q)))
    else $error("subtract wrong");
  dma_in_wr_a: assert property (state_q == imd_pkg::IMD_DMA && dma_is_in_q && phase_q == 3'h3 // [RULE6]
      |=> !mem_write_strobe_n_out && mem_read_strobe_n_out && mem_addr_out == dma_ptr_q)
    else $error("dma input strobes wrong");
  dma_ptr_step_a: assert property (state_q == imd_pkg::IMD_DMA && last_ph // [RULE7]
      |=> dma_ptr_q == $past(dma_ptr_q) + 16'h0001)
    else $error("dma pointer not stepped");
  dma_prio_a: assert property (state_q == imd_pkg::IMD_IDLE && dma_in_s && dma_out_s // [RULE8]
      |=> state_q == imd_pkg::IMD_DMA && dma_is_in_q)
    else $error("dma input not first");
  int_entry_a: assert property (state_q == imd_pkg::IMD_INT && last_ph // [RULE9]
      |=> !ie_q && cs_q == 4'h1 && ps_q == 4'h2 && saved_q == {$past(ps_q), $past(cs_q)})
    else $error("interrupt entry wrong");
  load_addr_a: assert property (state_q == imd_pkg::IMD_LOAD [*2] // [RULE10]
      |-> mem_addr_out == dma_ptr_q - 16'h0001 && !mem_read_strobe_n_out && mem_write_strobe_n_out)
    else $error("load idle address wrong");
  load_no_tpa_a: assert property (state_q == imd_pkg::IMD_LOAD |=> !timing_pulse_a_out) // [RULE11]
    else $error("pulse during load");
  shl_carry_a: assert property (s_commit(imd_pkg::IMD_OP_SHL) |=> // [RULE12]
      carry_q == $past(acc_q[7]) && acc_q == {$past(acc_q[6:0]), 1'b0} && pc_q == $past(pc_q))
    else $error("shift left wrong");
  io_code_zero_a: assert property (io_code_lines_out == 3'h0) // [RULE13]
    else $error("io code lines not zero");
endmodule

// ### src/imd_params.svh
// Constants for the immediate, DMA, interrupt and load cycle block.
// Assumes inclusion by bare name from the src/ folder.
`ifndef IMD_PARAMS_SVH
`define IMD_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define IMD_OFS_STATUS 8'h00
`define IMD_OFS_PC 8'h04
`define IMD_OFS_DMAPTR 8'h08
`define IMD_OFS_SEL 8'h0C
// ****************************************
// Field positions in the select register
// ****************************************
`define IMD_SEL_CS_LO 0
`define IMD_SEL_PS_LO 4
`define IMD_SEL_IE_BIT 8
`define IMD_SEL_SAVED_LO 16
// ****************************************
// Reset values and entry values
// ****************************************
`define IMD_RST_PC 16'h0000
`define IMD_RST_DMAPTR 16'h0000
`define IMD_RST_ACC 8'h00
`define IMD_INT_CS 4'h1
`define IMD_INT_PS 4'h2
`define IMD_IMM_HI 4'hF
// ****************************************
// Machine cycle timing in clocks
// ****************************************
`define IMD_PH_TPA 3'h0
`define IMD_PH_CAP 3'h6
`define IMD_PH_LAST 3'h7
`endif

// ### src/imd_pkg.sv
// Types shared by the immediate, DMA, interrupt and load cycle block.
// Assumes nothing of its surroundings.
package imd_pkg;
  // Cycle kind, Gray coded along idle-exec-dma-int-load
  typedef enum logic [2:0] {
    IMD_IDLE = 3'b000,
    IMD_EXEC = 3'b001,
    IMD_DMA = 3'b011,
    IMD_INT = 3'b010,
    IMD_LOAD = 3'b110
  } imd_state_t;
  // Operation, coded as the opcode low nibble
  typedef enum logic [3:0] {
    IMD_OP_LOAD = 4'h8,
    IMD_OP_OR = 4'h9,
    IMD_OP_AND = 4'hA,
    IMD_OP_XOR = 4'hB,
    IMD_OP_ADD = 4'hC,
    IMD_OP_RSUB = 4'hD,
    IMD_OP_SHL = 4'hE,
    IMD_OP_SUB = 4'hF
  } imd_op_t;
endpackage

// ### src/imd_alu_if.sv
// Carrier between the cycle sequencer and its arithmetic unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface imd_alu_if;
  imd_pkg::imd_op_t op; // Operation
  logic [7:0] acc; // Accumulator in
  logic [7:0] operand; // Immediate byte
  logic [7:0] result; // New accumulator
  logic carry_out; // New carry bit
  logic carry_we; // Carry bit changes
  modport core (output op, acc, operand, input result, carry_out, carry_we);
  modport alu (input op, acc, operand, output result, carry_out, carry_we);
endinterface

// ### src/imd_alu.sv
// Arithmetic unit for the immediate operations, purely combinational.
// Assumes the sequencer holds its inputs stable while it commits.
`timescale 1ns/1ps
module imd_alu (
  // Operation and results
  imd_alu_if.alu a
);
  logic [8:0] sum; // Acc plus operand
  logic [8:0] dif_r; // Operand minus acc
  logic [8:0] dif_s; // Acc minus operand

  // Carry on subtract is high when no borrow occurred
  always_comb begin
    sum = {1'b0, a.acc} + {1'b0, a.operand};
    dif_r = {1'b0, a.operand} + {1'b0, ~a.acc} + 9'h001;
    dif_s = {1'b0, a.acc} + {1'b0, ~a.operand} + 9'h001;
    a.result = a.acc;
    a.carry_out = 1'b0;
    a.carry_we = 1'b0;
    unique case (a.op)
      imd_pkg::IMD_OP_LOAD: a.result = a.operand;
      imd_pkg::IMD_OP_OR: a.result = a.acc | a.operand;
      imd_pkg::IMD_OP_AND: a.result = a.acc & a.operand;
      imd_pkg::IMD_OP_XOR: a.result = a.acc ^ a.operand;
      imd_pkg::IMD_OP_ADD: begin
        a.result = sum[7:0];
        a.carry_out = sum[8];
        a.carry_we = 1'b1;
      end
      imd_pkg::IMD_OP_RSUB: begin
        a.result = dif_r[7:0];
        a.carry_out = dif_r[8];
        a.carry_we = 1'b1;
      end
      imd_pkg::IMD_OP_SUB: begin
        a.result = dif_s[7:0];
        a.carry_out = dif_s[8];
        a.carry_we = 1'b1;
      end
      imd_pkg::IMD_OP_SHL: begin
        a.result = {a.acc[6:0], 1'b0};
        a.carry_out = a.acc[7];
        a.carry_we = 1'b1;
      end
    endcase
  end
endmodule

// ### src/imd_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module imd_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // First stage, read by second only

  // Two stages per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        meta_q[i] <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule

// ### sim/imd_mem_model.sv
// Memory and I/O device model on the far side of the core's bus.
// Assumes a 256 byte space (address low byte) and a single clock.
`timescale 1ns/1ps
module imd_mem_model (
  // Clock
  input wire logic clk_in,
  // Bus from the core
  input wire logic [15:0] addr_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  // I/O device side
  input wire logic io_drive_in,
  input wire logic [7:0] io_byte_in,
  // Data bus towards the core
  output logic [7:0] bus_out
);
  // ****************************************
  // Storage and bus
  // ****************************************
  logic [7:0] mem [0:255]; // Memory bytes
  logic [7:0] last_q = 8'h00; // Last bus value, inverted when nobody drives
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Memory answers reads, the I/O device drives DMA input bytes
  always_comb begin
    if (!rd_n_in) begin
      bus_out = mem[addr_in[7:0]];
    end else if (io_drive_in) begin
      bus_out = io_byte_in;
    end else begin
      bus_out = ~last_q; // Released bus shows no stale value
    end
  end
  // Writes land while the write strobe is low
  always @(posedge clk_in) begin
    last_q <= bus_out;
    if (!wr_n_in) begin
      mem[addr_in[7:0]] <= bus_out;
    end
  end
endmodule

// ### sim/test_immediate_ops_dma_interrupt_cycles.sv
// Self-checking bench for the immediate, DMA, interrupt and load cycles.
// Assumes the core from src/ and the memory model from sim/.
`timescale 1ns/1ps
module test_immediate_ops_dma_interrupt_cycles;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 0, rst = 1, wr = 0, rd = 0, req = 0, io_drive = 0;
  logic clear_n = 1, wait_n = 1, din_n = 1, dout_n = 1, int_n = 1;
  logic [7:0] addr = 8'h00, opc = 8'h00, io_byte = 8'h00, bus;
  logic [31:0] wdata = 32'h0000_0000, rdata, got;
  logic done, rd_n, wr_n, timing_pulse_a, timing_pulse_b;
  logic [15:0] maddr;
  logic [2:0] ioc;
  imd_pkg::imd_state_t st;
  int n_mismatch = 0, tests_run = 0;
  logic [7:0] e_acc = 8'h00, v;
  logic e_c = 1'b0;
  logic [15:0] e_pc = 16'h0000, ptr;
  always #5 clk = ~clk;
  imd_core imd_core_inst (.core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .exec_req_in(req), .exec_opcode_in(opc),
    .exec_done_out(done), .clear_n_in(clear_n), .wait_n_in(wait_n), .dma_in_req_n_in(din_n),
    .dma_out_req_n_in(dout_n), .int_req_n_in(int_n), .data_in(bus), .mem_addr_out(maddr),
    .mem_read_strobe_n_out(rd_n), .mem_write_strobe_n_out(wr_n), .timing_pulse_a_out(timing_pulse_a),
    .timing_pulse_b_out(timing_pulse_b), .io_code_lines_out(ioc), .state_out(st));
  imd_mem_model imd_mem_model_inst (.clk_in(clk), .addr_in(maddr), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .io_drive_in(io_drive), .io_byte_in(io_byte), .bus_out(bus));
  // ****************************************
  // Tasks and reference
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 d = rdata;
  endtask
  // Wait for a cycle kind, bounded
  task automatic wait_st(input imd_pkg::imd_state_t s);
    int n;
    n = 0;
    while (st !== s && n < 200) begin
      @(posedge clk) n++;
    end
    #1 chk({29'h0, st}, {29'h0, s});
  endtask
  // Expected {carry, accumulator} after an immediate operation
  function automatic logic [8:0] ref_op(input logic [3:0] op, input logic [7:0] a, input logic [7:0] m,
    input logic c);
    case (op)
      4'h8: ref_op = {c, m};
      4'h9: ref_op = {c, a | m};
      4'hA: ref_op = {c, a & m};
      4'hB: ref_op = {c, a ^ m};
      4'hC: ref_op = {1'b0, a} + {1'b0, m};
      4'hD: ref_op = {m >= a, m - a};
      4'hE: ref_op = {a[7], a[6:0], 1'b0};
      default: ref_op = {a >= m, a - m};
    endcase
  endfunction
  // One immediate instruction, then accumulator, carry and counter checked
  task automatic do_op(input logic [3:0] op, input logic [7:0] m);
    int n;
    imd_mem_model_inst.mem[e_pc[7:0]] = m;
    @(posedge clk) begin req <= 1; opc <= {4'hF, op}; end
    @(posedge clk) req <= 0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk) n++;
    end
    chk({23'h0, done, n[7:0]}, {23'h0, 1'b1, 8'h0A});
    {e_c, e_acc} = ref_op(op, e_acc, m, e_c);
    if (op != 4'hE) begin
      e_pc = e_pc + 16'h0001;
    end
    reg_rd(8'h00, got);
    chk(got & 32'h0000_01FF, {23'h0, e_c, e_acc});
    reg_rd(8'h04, got);
    chk(got, {16'h0, e_pc});
  endtask
  // One DMA cycle; input selects the input request, both with input raises both
  task automatic do_dma(input logic in_req, input logic both);
    ptr = 16'h0040 + 16'($urandom_range(0, 63));
    v = 8'($urandom);
    reg_wr(8'h08, {16'h0, ptr});
    if (!in_req) begin
      imd_mem_model_inst.mem[ptr[7:0]] = v;
    end
    @(posedge clk) begin io_byte <= v; io_drive <= in_req; din_n <= !in_req; dout_n <= in_req && !both; end
    wait_st(imd_pkg::IMD_DMA);
    repeat (3) @(posedge clk);
    #1 chk({30'h0, rd_n, wr_n}, in_req ? 32'h2 : 32'h1);
    chk({8'h00, maddr, bus}, {8'h00, ptr, v});
    @(posedge clk) begin din_n <= 1; dout_n <= 1; end
    wait_st(imd_pkg::IMD_IDLE);
    io_drive <= 0;
    chk({24'h0, imd_mem_model_inst.mem[ptr[7:0]]}, {24'h0, v});
    reg_rd(8'h08, got);
    chk(got, {16'h0, ptr + 16'h0001});
    $display("DMA test done, input %0d both %0d", in_req, both);
  endtask
  // ****************************************
  // Checks on every cycle and watchdog
  // ****************************************
  always @(negedge clk) begin
    if (!rst && ioc !== 3'h0) begin
      chk({29'h0, ioc}, 32'h0);
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(4042));
    repeat (16) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    // Corner values: carry out of add, equal subtracts, shift of top bit
    do_op(4'h8, 8'hFF);
    do_op(4'hC, 8'h01);
    do_op(4'hF, 8'h00);
    do_op(4'hD, 8'h00);
    do_op(4'h8, 8'h80);
    do_op(4'hE, 8'h00);
    // Random operands over every operation
    for (int r = 0; r < 3; r++) begin
      for (int k = 8; k < 16; k++) begin
        do_op(4'(k), 8'($urandom));
      end
    end
    $display("Immediate test done");
    do_dma(1, 0);
    do_dma(1, 1);
    do_dma(0, 0);
    // Interrupt entry saves and replaces the selects
    reg_wr(8'h0C, 32'h0000_0153);
    @(posedge clk) int_n <= 0;
    wait_st(imd_pkg::IMD_INT);
    @(posedge clk) int_n <= 1;
    repeat (3) @(posedge clk);
    #1 chk({30'h0, rd_n, wr_n}, 32'h3);
    wait_st(imd_pkg::IMD_IDLE);
    reg_rd(8'h0C, got);
    chk(got & 32'h00FF_01FF, 32'h0053_0021);
    $display("Interrupt test done");
    // Load mode idles on pointer minus one, then takes a DMA input
    ptr = 16'h0020;
    v = 8'($urandom);
    reg_wr(8'h08, {16'h0, ptr});
    @(posedge clk) begin clear_n <= 0; wait_n <= 0; end
    wait_st(imd_pkg::IMD_LOAD);
    repeat (12) begin
      @(posedge clk) #1 chk({12'h0, maddr, rd_n, wr_n, timing_pulse_a, timing_pulse_b}, {12'h0, ptr - 16'h0001, 4'h4});
    end
    @(posedge clk) begin io_byte <= v; io_drive <= 1; din_n <= 0; end
    wait_st(imd_pkg::IMD_DMA);
    @(posedge clk) begin din_n <= 1; clear_n <= 1; wait_n <= 1; end
    wait_st(imd_pkg::IMD_IDLE);
    io_drive <= 0;
    chk({24'h0, imd_mem_model_inst.mem[ptr[7:0]]}, {24'h0, v});
    $display("Load test done");
    results();
  end
endmodule
